// ---- design/adcsr_pkg.sv ----
// constants, register map and helpers for the adc serial register map
// Functional notes
// - decode 0x00-0x02 as chip configuration
// - decode 0x05 and 0xFF as index/transfer
// - decode 0x08-0x22 as converter function registers
// - clock control 0x09 resets to 0x01
// - clear bit 0, transfer: stabilizer off
// - staged writes apply only on transfer
// - defaults loaded on reset before access
// - 16-bit instruction, then data bytes applied
package adcsr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CFG_LO = 8'h00; // port configuration
  localparam logic [7:0] ADDR_CHIP_ID = 8'h01; // read-only identity
  localparam logic [7:0] ADDR_CFG_HI = 8'h02; // read-only grade
  localparam logic [7:0] ADDR_INDEX = 8'h05; // device_index_select
  localparam logic [7:0] ADDR_XFER = 8'hFF; // settings_transfer
  localparam logic [7:0] ADDR_FN_LO = 8'h08; // first function register
  localparam logic [7:0] ADDR_FN_HI = 8'h22; // last function register
  localparam logic [7:0] ADDR_CLOCK = 8'h09; // clock_control
  localparam int FN_COUNT = 27; // 0x08..0x22 inclusive

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] CFG_RESET = 8'h18; // msb first, soft reset off
  localparam logic [7:0] CLOCK_RESET = 8'h01; // stabilizer on
  localparam logic [7:0] INDEX_RESET = 8'h0F; // all four channels addressed
  localparam logic [7:0] ZERO_BYTE = 8'h00; // reserved / unmapped value
  localparam int XFER_BIT = 0; // transfer strobe bit
  localparam int DCS_BIT = 0; // stabilizer enable field

  // ****************************************
  // serial instruction layout
  // ****************************************
  localparam int INSTR_RW_BIT = 15; // 1 = read
  localparam int INSTR_W_HI = 14; // byte count code, upper
  localparam int INSTR_W_LO = 13; // byte count code, lower
  localparam logic [3:0] INSTR_LAST = 4'hF; // 16th instruction bit
  localparam logic [3:0] BYTE_LAST = 4'h7; // 8th data bit
  localparam logic [1:0] W_STREAM = 2'h3; // streaming code

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic in_fn_region(input logic [7:0] a);
    return (a >= ADDR_FN_LO) && (a <= ADDR_FN_HI);
  endfunction

  function automatic logic [4:0] fn_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_FN_LO;
    return d[4:0];
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a <= ADDR_CFG_HI) || (a == ADDR_INDEX) || (a == ADDR_XFER) || in_fn_region(a);
  endfunction

  function automatic logic [7:0] fn_default(input int i);
    return (i == int'(fn_index(ADDR_CLOCK))) ? CLOCK_RESET : ZERO_BYTE;
  endfunction

endpackage

// ---- design/adcsr_spi_frame.sv ----
// serial frame engine: instruction, byte count, read shift-out
`timescale 1ns/10ps
`default_nettype none
module adcsr_spi_frame
  import adcsr_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic reset_in, // async reset, high
  input wire logic sclk_in, // serial clock, sampled
  input wire logic csb_n_in, // chip select, low active
  input wire logic sdio_in, // serial data pin, input side
  input wire logic [7:0] rd_data_in, // byte at rd_addr_out
  output logic wr_stb_out, // one-cycle write strobe
  output logic [7:0] wr_addr_out, // write address
  output logic [7:0] wr_data_out, // write data
  output logic [7:0] rd_addr_out, // current byte address
  output logic sdio_out, // serial data pin, output side
  output logic sdio_oe_out // high while driving sdio
);

  typedef enum logic [0:0] {ST_INSTR, ST_DATA} adcsr_frame_t;

  adcsr_frame_t state_reg; // frame phase
  logic sclk_prev_reg; // last sampled sclk
  logic [3:0] bit_cnt_reg; // bits taken in current word
  logic [15:0] shift_reg; // incoming shift register
  logic [7:0] addr_reg; // running byte address
  logic is_read_reg; // frame is a readback
  logic stream_reg; // streaming until csb rises
  logic [1:0] left_reg; // bytes remaining after current
  logic load_reg; // refill tx one cycle after address moves
  logic [7:0] tx_reg; // outgoing byte
  logic rise; // host sample edge
  logic fall; // device drive edge
  logic abort; // csb high inside a byte or ending a stream

  assign rise = sclk_in && !sclk_prev_reg && !csb_n_in;
  assign fall = !sclk_in && sclk_prev_reg && !csb_n_in;
  // a byte may stall with csb high only at a boundary of a counted transfer
  assign abort = csb_n_in && ((bit_cnt_reg != 4'h0) || stream_reg || state_reg == ST_INSTR);
  assign rd_addr_out = addr_reg;
  assign sdio_out = tx_reg[7];
  assign sdio_oe_out = is_read_reg && state_reg == ST_DATA && !csb_n_in;

  // ****************************************
  // edge tracking
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_in;
    end
  end

  // ****************************************
  // instruction and data sequencing
  // ****************************************
  // address walks downward in streams, as msb-first parts do
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ST_INSTR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 16'h0000;
      addr_reg <= 8'h00;
      is_read_reg <= 1'b0;
      stream_reg <= 1'b0;
      left_reg <= 2'h0;
      load_reg <= 1'b0;
      wr_stb_out <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
    end else begin
      wr_stb_out <= 1'b0;
      load_reg <= 1'b0;
      if (abort) begin
        // lost frame: wait for a fresh instruction
        state_reg <= ST_INSTR;
        bit_cnt_reg <= 4'h0;
        stream_reg <= 1'b0;
        is_read_reg <= 1'b0;
      end else if (rise) begin
        shift_reg <= {shift_reg[14:0], sdio_in};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (state_reg == ST_INSTR && bit_cnt_reg == INSTR_LAST) begin
          state_reg <= ST_DATA;
          bit_cnt_reg <= 4'h0;
          is_read_reg <= shift_reg[INSTR_RW_BIT - 1];
          left_reg <= shift_reg[INSTR_W_HI - 1:INSTR_W_LO - 1];
          stream_reg <= shift_reg[INSTR_W_HI - 1:INSTR_W_LO - 1] == W_STREAM;
          addr_reg <= {shift_reg[6:0], sdio_in};
          load_reg <= 1'b1;
        end else if (state_reg == ST_DATA && bit_cnt_reg == BYTE_LAST) begin
          // byte complete: hand a write over unless the frame is a read, step the address
          bit_cnt_reg <= 4'h0;
          wr_stb_out <= !is_read_reg;
          wr_addr_out <= addr_reg;
          wr_data_out <= {shift_reg[6:0], sdio_in};
          addr_reg <= addr_reg - 8'h01;
          load_reg <= 1'b1;
          if (!stream_reg) begin
            left_reg <= left_reg - 2'h1;
            if (left_reg == 2'h0) begin
              state_reg <= ST_INSTR;
              is_read_reg <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // readback shifter
  // ****************************************
  // sclk high/low must span two clk_in cycles so the refill lands first
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_reg <= 8'h00;
    end else if (load_reg) begin
      tx_reg <= rd_data_in;
    end else if (fall && state_reg == ST_DATA && bit_cnt_reg != 4'h0) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  a_abort_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    abort |=> bit_cnt_reg == 4'h0 && state_reg == ST_INSTR)
    else $error("frame not reset by csb");
  a_strobe_in_data: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb_out |-> $past(state_reg) == ST_DATA && !$past(is_read_reg))
    else $error("write strobe outside data phase");

endmodule // adcsr_spi_frame
`default_nettype wire

// ---- design/adcsr_register_map.sv ----
// top: serial-port register map with staged converter settings
`timescale 1ns/10ps
`default_nettype none
module adcsr_register_map
  import adcsr_pkg::*;
#(
  parameter logic [7:0] CHIP_ID_VALUE = 8'h5A, // arbitrary identity value
  parameter logic [7:0] GRADE_VALUE = 8'h01 // arbitrary grade value
) (
  input wire logic clk_in, // 20 MHz system clock
  input wire logic reset_in, // async reset, high
  input wire logic sclk_in, // serial clock pin
  input wire logic csb_n_in, // chip select pin, low active
  input wire logic sdio_in, // serial data pin, input side
  output logic sdio_out, // serial data pin, output side
  output logic sdio_oe_out, // high while driving sdio
  output logic [7:0] port_config_out, // live port configuration
  output logic [7:0] device_index_out, // active channel index
  output logic [7:0] clock_ctrl_out, // active clock control
  output logic dcs_enable_out // duty cycle stabilizer on
);

  // the host sees one flat byte space; only 0x00 acts at once
  // every other setting waits in a shadow copy for the transfer strobe,
  // so a change spread over many registers reaches the converters in one cycle
  // limitation: the lsb-first and soft reset bits of 0x00 are stored, not acted on
  // identity and grade come from parameters, so they cost no flops
  // the serial framing lives in the frame engine; this level only decodes

  // ****************************************
  // storage
  // ****************************************
  // two copies of every staged byte cost flops but keep the live set
  // coherent: converters never see half of an update
  logic [7:0] cfg_reg; // port configuration, applies at once
  logic [7:0] index_shadow_reg; // written index, not yet live
  logic [7:0] index_active_reg; // live index
  logic [7:0] fn_shadow_reg [FN_COUNT]; // written function bytes
  logic [7:0] fn_active_reg [FN_COUNT]; // live function bytes
  logic wr_stb; // write strobe from frame engine
  logic [7:0] wr_addr; // write address
  logic [7:0] wr_data; // write data
  logic [7:0] rd_addr; // read address
  logic [7:0] rd_data; // decoded read byte
  logic xfer_pulse; // transfer bit written

  adcsr_spi_frame u_frame (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .sclk_in(sclk_in),
    .csb_n_in(csb_n_in),
    .sdio_in(sdio_in),
    .rd_data_in(rd_data),
    .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .rd_addr_out(rd_addr),
    .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out)
  );

  // transfer is a strobe: the register never holds the bit
  // so 0xFF always reads back as zero
  assign xfer_pulse = wr_stb && wr_addr == ADDR_XFER && wr_data[XFER_BIT];

  // ****************************************
  // chip configuration region
  // ****************************************
  // identity and grade are read-only; writes to them are dropped
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_stb && wr_addr == ADDR_CFG_LO) begin
      cfg_reg <= wr_data;
    end
  end

  // ****************************************
  // device index, staged
  // ****************************************
  // written index, read back before it goes live
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      index_shadow_reg <= INDEX_RESET;
    end else if (wr_stb && wr_addr == ADDR_INDEX) begin
      index_shadow_reg <= wr_data;
    end
  end

  // live index moves with the same strobe as the function bytes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      index_active_reg <= INDEX_RESET;
    end else if (xfer_pulse) begin
      index_active_reg <= index_shadow_reg;
    end
  end

  // ****************************************
  // converter function region, staged
  // ****************************************
  // shadow holds every byte the host writes; unmapped addresses fall through
  // reserved bytes are stored like the rest; the host keeps them at zero
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < FN_COUNT; i++) begin
        fn_shadow_reg[i] <= fn_default(i);
      end
    end else if (wr_stb && in_fn_region(wr_addr)) begin
      fn_shadow_reg[fn_index(wr_addr)] <= wr_data;
    end
  end

  // live copy moves only on the transfer strobe, all bytes at once
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < FN_COUNT; i++) begin
        fn_active_reg[i] <= fn_default(i);
      end
    end else if (xfer_pulse) begin
      for (int i = 0; i < FN_COUNT; i++) begin
        fn_active_reg[i] <= fn_shadow_reg[i];
      end
    end
  end

  // ****************************************
  // read decode
  // ****************************************
  // reads show the written (shadow) value so software can verify before transfer
  // limitation: the live copy itself cannot be read back over the port
  always_comb begin
    rd_data = ZERO_BYTE;
    if (in_fn_region(rd_addr)) begin
      rd_data = fn_shadow_reg[fn_index(rd_addr)];
    end else if (rd_addr == ADDR_CFG_LO) begin
      rd_data = cfg_reg;
    end else if (rd_addr == ADDR_CHIP_ID) begin
      rd_data = CHIP_ID_VALUE;
    end else if (rd_addr == ADDR_CFG_HI) begin
      rd_data = GRADE_VALUE;
    end else if (rd_addr == ADDR_INDEX) begin
      rd_data = index_shadow_reg;
    end
  end

  // ****************************************
  // live settings
  // ****************************************
  // straight from flops: no decode glitches reach the converters
  assign port_config_out = cfg_reg;
  assign device_index_out = index_active_reg;
  assign clock_ctrl_out = fn_active_reg[fn_index(ADDR_CLOCK)];
  assign dcs_enable_out = clock_ctrl_out[DCS_BIT];

  // ****************************************
  // checks
  // ****************************************
  // reset leaves every live output at its default
  a_clock_reset_default: assert property (@(posedge clk_in)
    $fell(reset_in) |-> clock_ctrl_out == CLOCK_RESET && dcs_enable_out)
    else $error("clock control not at default after reset");
  a_defaults_loaded: assert property (@(posedge clk_in)
    $fell(reset_in) |-> port_config_out == CFG_RESET && device_index_out == INDEX_RESET)
    else $error("defaults missing after reset");
  // staged bytes stay hidden until the transfer strobe
  a_staged_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb && in_fn_region(wr_addr) |=> $stable(clock_ctrl_out) && $stable(device_index_out))
    else $error("function write went live without transfer");
  a_xfer_copies: assert property (@(posedge clk_in) disable iff (reset_in)
    xfer_pulse |=> clock_ctrl_out == $past(fn_shadow_reg[fn_index(ADDR_CLOCK)])
      && device_index_out == $past(index_shadow_reg))
    else $error("transfer did not copy settings");
  a_dcs_turn_off: assert property (@(posedge clk_in) disable iff (reset_in)
    xfer_pulse && !fn_shadow_reg[fn_index(ADDR_CLOCK)][DCS_BIT] |=> !dcs_enable_out ##1 !dcs_enable_out || xfer_pulse)
    else $error("stabilizer still on after transfer");
  // live index and clock control move on the transfer strobe and at no other time
  a_live_only_xfer: assert property (@(posedge clk_in) disable iff (reset_in)
    !xfer_pulse |=> $stable(clock_ctrl_out) && $stable(device_index_out))
    else $error("live setting moved without transfer");
  // an index write lands in the shadow copy only
  a_index_staged: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb && wr_addr == ADDR_INDEX |=> index_shadow_reg == $past(wr_data) && $stable(device_index_out))
    else $error("index write not staged");
  // unmapped space reads zero and swallows writes
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    !is_mapped(rd_addr) || rd_addr == ADDR_XFER |-> rd_data == ZERO_BYTE)
    else $error("unmapped or transfer address read nonzero");
  a_unmapped_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb && !is_mapped(wr_addr) |=> $stable(cfg_reg) && $stable(index_shadow_reg))
    else $error("unmapped write changed a register");
  // read-only bytes ignore the host's writes
  a_identity_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_addr == ADDR_CHIP_ID |-> rd_data == CHIP_ID_VALUE)
    else $error("identity byte changed");
  a_grade_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_addr == ADDR_CFG_HI |-> rd_data == GRADE_VALUE)
    else $error("grade byte changed");
  // 0x00 goes live on the cycle after its write
  a_cfg_readback: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb && wr_addr == ADDR_CFG_LO |=> port_config_out == $past(wr_data))
    else $error("config write not applied");
  a_fn_readback: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_stb && in_fn_region(wr_addr) |=> fn_shadow_reg[fn_index($past(wr_addr))] == $past(wr_data))
    else $error("function write lost");
  // the device never drives the shared data line outside a frame
  a_no_drive_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    csb_n_in |-> !sdio_oe_out)
    else $error("sdio driven with chip select high");

  // ****************************************
  // cover points
  // ****************************************
  // the main scenarios the bench is meant to reach
  c_transfer: cover property (@(posedge clk_in) disable iff (reset_in) xfer_pulse);
  c_dcs_off: cover property (@(posedge clk_in) disable iff (reset_in) $fell(dcs_enable_out));
  c_readback: cover property (@(posedge clk_in) disable iff (reset_in) sdio_oe_out && in_fn_region(rd_addr));
  c_index_write: cover property (@(posedge clk_in) disable iff (reset_in) wr_stb && wr_addr == ADDR_INDEX);
  c_unmapped_write: cover property (@(posedge clk_in) disable iff (reset_in) wr_stb && !is_mapped(wr_addr));

endmodule // adcsr_register_map
`default_nettype wire

// ---- verification/adcsr_host_model.sv ----
// serial host model that drives the register map's control port
`timescale 1ns/10ps
`default_nettype none
module adcsr_host_model (
  input wire logic clk_in, // bench clock
  input wire logic sdio_in, // resolved sdio line
  output logic sclk_out, // serial clock, low outside frames
  output logic csb_n_out, // chip select, low active
  output logic sdio_out, // host data onto sdio
  output logic sdio_oe_out // high while host drives sdio
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    sclk_out = 1'b0;
    csb_n_out = 1'b1;
    sdio_out = 1'b0;
    sdio_oe_out = 1'b0;
  end

  // ****************************************
  // bit and frame tasks
  // ****************************************
  // one sclk period: two clocks low, two high; sample just before the rise
  task automatic bit_cyc(input logic b, input logic oe, output logic s);
    sclk_out <= 1'b0;
    sdio_out <= b;
    sdio_oe_out <= oe;
    repeat (2) @(posedge clk_in);
    s = sdio_in;
    sclk_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  // instruction then nbits data bits; a count short of a byte aborts the frame
  // writes to undefined places happen only when the bench commands them
  task automatic xfer(input logic rd, input logic [1:0] w, input logic [7:0] addr,
                      input int nbits, input logic [31:0] wd, output logic [31:0] rdv);
    logic [15:0] ins;
    logic s;
    ins = {rd, w, 5'h00, addr};
    rdv = 32'h0;
    @(posedge clk_in);
    csb_n_out <= 1'b0;
    @(posedge clk_in);
    for (int i = 15; i >= 0; i--) bit_cyc(ins[i], 1'b1, s);
    // a read releases sdio so the device can turn the line round
    for (int i = 0; i < nbits; i++) begin
      bit_cyc(wd[31 - i], !rd, s);
      rdv[31 - i] = s;
    end
    sclk_out <= 1'b0;
    @(posedge clk_in);
    csb_n_out <= 1'b1;
    sdio_oe_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule // adcsr_host_model
`default_nettype wire

// ---- verification/adcsr_register_map_bench.sv ----
// self-checking bench for the serial register map
`timescale 1ns/10ps
`default_nettype none
module adcsr_register_map_bench;
  import adcsr_pkg::*;
  localparam logic [7:0] ID_V = 8'h3C; // arbitrary identity value
  localparam logic [7:0] GRADE_V = 8'h02; // arbitrary grade value
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} adcsr_row_t;
  logic clk_in, reset_in, sclk, csb_n, host_d, host_oe, sdio_line, last_q;
  logic dut_d, dut_oe, dcs;
  logic [7:0] cfg, idx, clk_ctl, v;
  logic [31:0] r;
  int error_cnt, compares;
  // write, then read back: staged value, read-only, reserved or unmapped
  // undefined places are only ever given zero, the recommended value
  adcsr_row_t rows[13] = '{{8'h09, 8'h00, 8'h00}, {8'h22, 8'h3C, 8'h3C}, {8'h08, 8'h11, 8'h11},
    {8'h23, 8'h00, 8'h00}, {8'h07, 8'h00, 8'h00}, {8'h03, 8'h00, 8'h00}, {8'h30, 8'h00, 8'h00},
    {8'h0B, 8'h00, 8'h00}, {8'h05, 8'h03, 8'h03}, {8'hFF, 8'h00, 8'h00}, {8'h01, 8'hAA, ID_V},
    {8'h02, 8'hAA, GRADE_V}, {8'h00, 8'h18, CFG_RESET}};

  // ****************************************
  // clock, line resolution, instances
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // an undriven line toggles so a stale bit cannot pass for read data
  assign sdio_line = dut_oe ? dut_d : (host_oe ? host_d : ~last_q);
  initial last_q = 1'b0;
  always @(posedge clk_in) last_q <= sdio_line;

  adcsr_register_map #(.CHIP_ID_VALUE(ID_V), .GRADE_VALUE(GRADE_V)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .csb_n_in(csb_n), .sdio_in(sdio_line),
    .sdio_out(dut_d), .sdio_oe_out(dut_oe), .port_config_out(cfg), .device_index_out(idx),
    .clock_ctrl_out(clk_ctl), .dcs_enable_out(dcs));
  adcsr_host_model i_host (.clk_in(clk_in), .sdio_in(sdio_line), .sclk_out(sclk),
    .csb_n_out(csb_n), .sdio_out(host_d), .sdio_oe_out(host_oe));

  // ****************************************
  // helper tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, 2'h0, a, 8, {d, 24'h000000}, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_host.xfer(1'b1, 2'h0, a, 8, 32'h00000000, r);
    d = r[31:24];
  endtask
  // live outputs must show the defaults
  task automatic check_reset;
    check("port config", CFG_RESET, cfg);
    check("device index", INDEX_RESET, idx);
    check("clock control", CLOCK_RESET, clk_ctl);
    check("stabilizer", 8'h01, {7'h00, dcs});
    check("sdio enable", 8'h00, {7'h00, dut_oe});
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // watchdog, well past the roughly 3400 clocks the tests need
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    error_cnt = 0;
    compares = 0;
    reset_in = 1'b1;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    check_reset;
    // table rows: one write frame and one read frame each
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      check($sformatf("readback %h", rows[i].a), rows[i].e, v);
    end
    check("port config live", CFG_RESET, cfg);
    // staged writes stay hidden until a transfer with bit 0 set
    check("clock staged", CLOCK_RESET, clk_ctl);
    check("index staged", INDEX_RESET, idx);
    wr(ADDR_XFER, 8'h01);
    check("clock live", 8'h00, clk_ctl);
    check("stabilizer off", 8'h00, {7'h00, dcs});
    check("index live", 8'h03, idx);
    // two-byte write and read, address stepping down from 0x0A
    i_host.xfer(1'b0, 2'h1, 8'h0A, 16, {8'h5B, 8'h41, 16'h0000}, r);
    i_host.xfer(1'b1, 2'h1, 8'h0A, 16, 32'h00000000, r);
    check("multi byte 0A", 8'h5B, r[31:24]);
    check("multi byte 09", 8'h41, r[23:16]);
    check("clock before xfer", 8'h00, clk_ctl);
    wr(ADDR_XFER, 8'h01);
    check("clock after xfer", 8'h41, clk_ctl);
    check("stabilizer on", 8'h01, {7'h00, dcs});
    // chip select lifted mid byte drops the partial byte
    i_host.xfer(1'b0, 2'h0, ADDR_CLOCK, 4, 32'h00000000, r);
    rd(ADDR_CLOCK, v);
    check("aborted write", 8'h41, v);
    // second reset in mid run restores defaults, shadow included
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    check_reset;
    rd(ADDR_CLOCK, v);
    check("clock shadow reset", CLOCK_RESET, v);
    stop_test;
  end
endmodule // adcsr_register_map_bench
`default_nettype wire
